// file: pbs_pkg.sv
// Constants and types shared by the pipelined burst SRAM port.
// Assumes a by-18 organisation: two byte lanes, each with one parity bit.
package pbs_pkg;

	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int PAR_W = 2;
	localparam int LANES = 2;
	localparam int WORD_W = DATA_W + PAR_W;
	localparam int BUF_DEPTH = 2;

	localparam logic [1:0] BEAT_RST = 2'h0;
	localparam logic [1:0] BEAT_STEP = 2'h1;
	localparam logic [1:0] CNT_EMPTY = 2'h0;
	localparam logic [1:0] CNT_ONE = 2'h1;
	localparam logic [1:0] CNT_FULL = 2'h2;
	localparam logic [LANES-1:0] LANES_ALL = 2'h3;
	localparam logic [LANES-1:0] LANES_NONE = 2'h0;
	localparam logic [2:0] SYNC_RST = 3'h0;
	localparam logic MODE_RST = 1'b1;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] data;
		logic [LANES-1:0] lanes;
	} pbs_wr_entry_t;

	localparam pbs_wr_entry_t ENTRY_RST = '{addr: 20'h00000, data: 18'h00000, lanes: 2'h0};

	typedef struct packed {
		logic [ADDR_W-3:0] addr_hi;
		logic [1:0] start_lo;
		logic [1:0] beat;
		logic active;
		logic desel;
		logic rd_pend;
		logic [ADDR_W-1:0] rd_addr;
		logic drive;
		logic [WORD_W-1:0] dout;
		logic [2:0] sleep_sync;
		logic sleep;
		logic mode;
		logic mode_done;
		logic [1:0] cnt;
		pbs_wr_entry_t [BUF_DEPTH-1:0] ent;
	} pbs_state_t;

endpackage

// file: pbs_port.sv
// Synchronous control and data port of a pipelined burst SRAM (by-18).
// Assumes the array outside answers mem_rd_addr combinationally on mem_rdata
// and drains writes through the valid/ready pair; all strobes are on clk.
//
// Functional notes
// - Sample every synchronous input on clk rising
// - Advance low steps burst counter
// - Primary select active low, joins select
// - Processor strobe ignored when primary select high
// - Second select active high, joins select
// - Third select active low; single-select ignores it
// - Output enable gates data drive asynchronously
// - First read after deselect keeps outputs off
// - Master drives advance low for next beat
// - Processor strobe loads address and counter
// - Controller strobe loads address and counter
// - Both strobes low: processor strobe wins
// - Sleep input high: low power, keep contents
// - Write data registered on clk rising
// - Read data driven one clock later
// - Mode strap: low linear, high interleaved
// - All-bytes write writes every lane
// - Byte writes need gate low, lane low
// - Two-bit wrapping burst counter, four beats
`timescale 1ns/100ps
module pbs_port #(
	parameter bit SINGLE_SEL = 1'b0
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [pbs_pkg::ADDR_W-1:0] addr_in,
	input wire logic chip_sel_primary_n,
	input wire logic chip_sel_second_high,
	input wire logic chip_sel_third_n,
	input wire logic cpu_addr_strobe_n,
	input wire logic ctl_addr_strobe_n,
	input wire logic burst_step_n,
	input wire logic all_bytes_write_n,
	input wire logic byte_write_gate_n,
	input wire logic [pbs_pkg::LANES-1:0] byte_lane_sel_n,
	input wire logic out_enable_n,
	input wire logic sleep_req,
	input wire logic burst_mode_sel,
	input wire logic [pbs_pkg::DATA_W-1:0] dq_in,
	output logic [pbs_pkg::DATA_W-1:0] dq_out,
	output logic dq_oe,
	input wire logic [pbs_pkg::PAR_W-1:0] parity_in,
	output logic [pbs_pkg::PAR_W-1:0] parity_out,
	output logic parity_oe,
	output logic [pbs_pkg::ADDR_W-1:0] mem_rd_addr,
	input wire logic [pbs_pkg::WORD_W-1:0] mem_rdata,
	output logic mem_wr_valid,
	input wire logic mem_wr_ready,
	output logic [pbs_pkg::ADDR_W-1:0] mem_wr_addr,
	output logic [pbs_pkg::WORD_W-1:0] mem_wr_data,
	output logic [pbs_pkg::LANES-1:0] mem_wr_lanes,
	output logic wbuf_ready,
	output logic mem_sleep
);

	pbs_pkg::pbs_state_t s_r;
	pbs_pkg::pbs_state_t s_nxt;

	logic sel_now;
	logic cpu_acc;
	logic ctl_acc;
	logic start;
	logic live;
	logic do_wr;
	logic pop;
	logic push;
	logic [1:0] beat_use;
	logic [1:0] lo_use;
	logic [1:0] slot;
	logic [pbs_pkg::ADDR_W-1:0] eff_addr;
	logic [pbs_pkg::LANES-1:0] wr_lanes;
	pbs_pkg::pbs_wr_entry_t new_ent;

	always_comb begin
		s_nxt = s_r;
		beat_use = s_r.beat;
		lo_use = 2'h0;
		slot = 2'h0;
		eff_addr = {s_r.addr_hi, 2'h0};
		wr_lanes = pbs_pkg::LANES_NONE;
		new_ent = pbs_pkg::ENTRY_RST;

		// Sleep input: third and second stage must agree before it counts
		s_nxt.sleep_sync = {s_r.sleep_sync[1:0], sleep_req};
		if (s_r.sleep_sync[1] == s_r.sleep_sync[2]) begin
			s_nxt.sleep = s_r.sleep_sync[2];
		end

		// Strap is caught once, on the first edge after reset release
		if (!s_r.mode_done) begin
			s_nxt.mode = burst_mode_sel;
			s_nxt.mode_done = 1'b1;
		end

		sel_now = !chip_sel_primary_n && chip_sel_second_high
			&& (SINGLE_SEL || !chip_sel_third_n);
		cpu_acc = !cpu_addr_strobe_n && !chip_sel_primary_n;
		ctl_acc = !ctl_addr_strobe_n && !cpu_acc;
		start = (cpu_acc || ctl_acc) && !s_r.sleep;

		if (start) begin
			s_nxt.addr_hi = addr_in[pbs_pkg::ADDR_W-1:2];
			s_nxt.start_lo = addr_in[1:0];
			s_nxt.beat = pbs_pkg::BEAT_RST;
			s_nxt.active = sel_now;
			s_nxt.desel = !sel_now;
			eff_addr = addr_in;
		end else begin
			if (s_r.active && !burst_step_n) begin
				beat_use = s_r.beat + pbs_pkg::BEAT_STEP;
				s_nxt.beat = beat_use;
			end
			if (s_r.mode) begin
				lo_use = s_r.start_lo ^ beat_use;
			end else begin
				lo_use = s_r.start_lo + beat_use;
			end
			eff_addr = {s_r.addr_hi, lo_use};
		end

		live = (start ? sel_now : s_r.active) && !s_r.sleep;

		if (!all_bytes_write_n) begin
			wr_lanes = pbs_pkg::LANES_ALL;
		end else if (!byte_write_gate_n) begin
			wr_lanes = ~byte_lane_sel_n;
		end
		do_wr = live && (wr_lanes != pbs_pkg::LANES_NONE);

		// Read pipeline: address held one clock, then data registered out
		s_nxt.rd_pend = live && !do_wr;
		s_nxt.rd_addr = eff_addr;
		if (s_r.rd_pend) begin
			s_nxt.dout = mem_rdata;
		end
		s_nxt.drive = s_r.rd_pend && !s_r.sleep;
		if (start && !sel_now) begin
			s_nxt.drive = 1'b0;
		end
		if (start && sel_now && s_r.desel) begin
			s_nxt.drive = 1'b0;
		end

		// Two-entry write buffer, head at entry 0
		new_ent.addr = eff_addr;
		new_ent.data = {parity_in, dq_in};
		new_ent.lanes = wr_lanes;
		pop = (s_r.cnt != pbs_pkg::CNT_EMPTY) && mem_wr_ready;
		slot = pop ? s_r.cnt - pbs_pkg::CNT_ONE : s_r.cnt;
		push = do_wr && (slot != pbs_pkg::CNT_FULL);
		if (pop) begin
			s_nxt.ent[0] = s_r.ent[1];
			s_nxt.ent[1] = pbs_pkg::ENTRY_RST;
		end
		if (push) begin
			s_nxt.ent[slot[0]] = new_ent;
		end
		s_nxt.cnt = slot + (push ? pbs_pkg::CNT_ONE : pbs_pkg::CNT_EMPTY);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '{addr_hi: '0, start_lo: 2'h0, beat: pbs_pkg::BEAT_RST, active: 1'b0,
				desel: 1'b1, rd_pend: 1'b0, rd_addr: '0, drive: 1'b0, dout: '0,
				sleep_sync: pbs_pkg::SYNC_RST, sleep: 1'b0, mode: pbs_pkg::MODE_RST,
				mode_done: 1'b0, cnt: pbs_pkg::CNT_EMPTY,
				ent: {pbs_pkg::ENTRY_RST, pbs_pkg::ENTRY_RST}};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dq_out = s_r.dout[pbs_pkg::DATA_W-1:0];
	assign parity_out = s_r.dout[pbs_pkg::WORD_W-1:pbs_pkg::DATA_W];
	assign dq_oe = s_r.drive && !out_enable_n;
	assign parity_oe = s_r.drive && !out_enable_n;
	assign mem_rd_addr = s_r.rd_addr;
	assign mem_wr_valid = s_r.cnt != pbs_pkg::CNT_EMPTY;
	assign mem_wr_addr = s_r.ent[0].addr;
	assign mem_wr_data = s_r.ent[0].data;
	assign mem_wr_lanes = s_r.ent[0].lanes;
	assign wbuf_ready = s_r.cnt != pbs_pkg::CNT_FULL;
	assign mem_sleep = s_r.sleep;

	sequence seq_sel_read;
		start && sel_now && !do_wr;
	endsequence

	sequence seq_data_out;
		s_r.rd_pend ##1 s_r.drive;
	endsequence

	// A deselecting strobe on the beat after the read may still cut the drive
	a_read_pipe_drive: assert property (@(posedge clk) disable iff (!rst_b)
		seq_sel_read ##0 !s_r.sleep ##1 (!s_r.sleep && !(start && !sel_now)) |-> seq_data_out)
		else $error("read data not driven one clock after address");

	a_start_addr_read: assert property (@(posedge clk) disable iff (!rst_b)
		start |=> mem_rd_addr == $past(addr_in))
		else $error("array not addressed with the strobed address");

	a_drive_after_read: assert property (@(posedge clk) disable iff (!rst_b)
		s_r.drive |-> $past(s_r.rd_pend))
		else $error("data driven without a pending read");

	a_addr_hi_load: assert property (@(posedge clk) disable iff (!rst_b)
		start |=> s_r.addr_hi == $past(addr_in[pbs_pkg::ADDR_W-1:2]))
		else $error("upper address not loaded on strobe");

	a_cpu_load: assert property (@(posedge clk) disable iff (!rst_b)
		(cpu_acc && !s_r.sleep) |=> s_r.start_lo == $past(addr_in[1:0]) && s_r.beat == 2'h0)
		else $error("processor strobe did not load counter");

	a_ctl_load: assert property (@(posedge clk) disable iff (!rst_b)
		(!ctl_addr_strobe_n && !cpu_acc && !s_r.sleep) |=> s_r.start_lo == $past(addr_in[1:0]))
		else $error("controller strobe did not load counter");

	a_cpu_ignored: assert property (@(posedge clk) disable iff (!rst_b)
		(!cpu_addr_strobe_n && chip_sel_primary_n && ctl_addr_strobe_n) |-> !start)
		else $error("processor strobe taken with primary select high");

	a_sel_all_three: assert property (@(posedge clk) disable iff (!rst_b)
		start |=> s_r.active == $past(!chip_sel_primary_n && chip_sel_second_high
			&& (SINGLE_SEL || !chip_sel_third_n)))
		else $error("selection does not follow the three selects");

	a_second_low_desel: assert property (@(posedge clk) disable iff (!rst_b)
		(start && !chip_sel_second_high) |=> !s_r.active && s_r.desel)
		else $error("second select low did not deselect");

	a_third_high_desel: assert property (@(posedge clk) disable iff (!rst_b)
		(start && chip_sel_third_n && !SINGLE_SEL) |=> !s_r.active)
		else $error("third select high did not deselect");

	a_read_pipe_data: assert property (@(posedge clk) disable iff (!rst_b)
		s_r.rd_pend |=> s_r.dout == $past(mem_rdata))
		else $error("read data not taken from addressed location");

	a_oe_async_gate: assert property (@(posedge clk) disable iff (!rst_b)
		dq_oe == (s_r.drive && !out_enable_n))
		else $error("output enable does not gate data drive");

	a_desel_stops_drive: assert property (@(posedge clk) disable iff (!rst_b)
		(start && !sel_now) |=> !s_r.drive && !s_r.active ##1 !s_r.drive)
		else $error("data still driven after deselect");

	a_first_read_masked: assert property (@(posedge clk) disable iff (!rst_b)
		(start && sel_now && s_r.desel) |=> !dq_oe)
		else $error("outputs driven on first read after deselect");

	a_cpu_ignored_unsel: assert property (@(posedge clk) disable iff (!rst_b)
		(chip_sel_primary_n && ctl_addr_strobe_n && !s_r.active) |=> !s_r.active)
		else $error("processor strobe started access with primary select high");

	a_strobe_priority: assert property (@(posedge clk) disable iff (!rst_b)
		(!cpu_addr_strobe_n && !ctl_addr_strobe_n && !chip_sel_primary_n && !s_r.sleep)
		|=> s_r.start_lo == $past(addr_in[1:0]) && s_r.beat == pbs_pkg::BEAT_RST)
		else $error("strobe load wrong when both strobes low");

	a_burst_step: assert property (@(posedge clk) disable iff (!rst_b)
		(s_r.active && !start && !burst_step_n) |=> s_r.beat == $past(s_r.beat) + 2'h1)
		else $error("burst counter did not step on advance");

	a_burst_hold: assert property (@(posedge clk) disable iff (!rst_b)
		(s_r.active && !start && burst_step_n) |=> $stable(s_r.beat))
		else $error("burst counter moved without advance");

	a_step_idle_hold: assert property (@(posedge clk) disable iff (!rst_b)
		(!s_r.active && !start) |=> $stable(s_r.beat))
		else $error("burst counter moved while idle");

	a_burst_wrap: assert property (@(posedge clk) disable iff (!rst_b)
		(s_r.active && !start && !burst_step_n && s_r.beat == 2'h3) |=> s_r.beat == 2'h0)
		else $error("burst counter did not wrap");

	a_upper_fixed: assert property (@(posedge clk) disable iff (!rst_b)
		(s_r.active && !start) |=> mem_rd_addr[pbs_pkg::ADDR_W-1:2] == s_r.addr_hi)
		else $error("upper address moved during burst");

	a_ilv_order: assert property (@(posedge clk) disable iff (!rst_b)
		(s_r.active && !start && s_r.mode) |=> mem_rd_addr[1:0] == (s_r.start_lo ^ s_r.beat))
		else $error("interleaved burst address wrong");

	a_lin_order: assert property (@(posedge clk) disable iff (!rst_b)
		(s_r.active && !start && !s_r.mode) |=> mem_rd_addr[1:0] == 2'(s_r.start_lo + s_r.beat))
		else $error("linear burst address wrong");

	a_mode_static: assert property (@(posedge clk) disable iff (!rst_b)
		s_r.mode_done |=> $stable(s_r.mode))
		else $error("burst order changed after capture");

	a_oe_high_off: assert property (@(posedge clk) disable iff (!rst_b)
		out_enable_n |-> !dq_oe && !parity_oe)
		else $error("data driven with output enable high");

	a_global_write: assert property (@(posedge clk) disable iff (!rst_b)
		(live && !all_bytes_write_n && s_r.cnt == pbs_pkg::CNT_EMPTY)
		|=> mem_wr_valid && mem_wr_lanes == pbs_pkg::LANES_ALL)
		else $error("global write did not enable every lane");

	a_byte_gate: assert property (@(posedge clk) disable iff (!rst_b)
		(all_bytes_write_n && byte_write_gate_n) |-> !do_wr)
		else $error("byte write without byte write gate");

	a_byte_lanes: assert property (@(posedge clk) disable iff (!rst_b)
		(live && all_bytes_write_n && !byte_write_gate_n && byte_lane_sel_n != 2'h3
			&& s_r.cnt == pbs_pkg::CNT_EMPTY) |=> mem_wr_lanes == $past(~byte_lane_sel_n))
		else $error("byte write lanes do not follow lane selects");

	a_wr_data_capture: assert property (@(posedge clk) disable iff (!rst_b)
		(live && !all_bytes_write_n && s_r.cnt == pbs_pkg::CNT_EMPTY)
		|=> mem_wr_data == $past({parity_in, dq_in}))
		else $error("write data not registered");

	a_buf_hold_stall: assert property (@(posedge clk) disable iff (!rst_b)
		(mem_wr_valid && !mem_wr_ready)
		|=> mem_wr_valid && $stable(mem_wr_data) && $stable(mem_wr_addr))
		else $error("write head lost while array stalls");

	a_sleep_filter: assert property (@(posedge clk) disable iff (!rst_b)
		sleep_req [*4] |=> mem_sleep)
		else $error("sleep not entered after stable request");

	a_sleep_exit: assert property (@(posedge clk) disable iff (!rst_b)
		!sleep_req [*4] |=> !mem_sleep)
		else $error("sleep not left after stable release");

	a_sleep_no_start: assert property (@(posedge clk) disable iff (!rst_b)
		s_r.sleep |-> !start)
		else $error("access started while asleep");

	a_sleep_no_drive: assert property (@(posedge clk) disable iff (!rst_b)
		s_r.sleep |=> !s_r.drive)
		else $error("data driven while asleep");

	a_buf_no_overflow: assert property (@(posedge clk) disable iff (!rst_b)
		s_r.cnt <= pbs_pkg::CNT_FULL)
		else $error("write buffer count out of range");

endmodule // pbs_port

// file: pbs_mem_model.sv
// Array model on the far side of the port's mem_* pins.
// Assumes one clk; only address bits 3:0 index its sixteen words.
`timescale 1ns/100ps
module pbs_mem_model (
	input wire logic clk,
	input wire logic stall,
	input wire logic [pbs_pkg::ADDR_W-1:0] mem_rd_addr,
	output logic [pbs_pkg::WORD_W-1:0] mem_rdata,
	input wire logic mem_wr_valid,
	output logic mem_wr_ready,
	input wire logic [pbs_pkg::ADDR_W-1:0] mem_wr_addr,
	input wire logic [pbs_pkg::WORD_W-1:0] mem_wr_data,
	input wire logic [pbs_pkg::LANES-1:0] mem_wr_lanes
);
	logic [pbs_pkg::WORD_W-1:0] mem [16];
	initial begin
		for (int i = 0; i < 16; i++) begin
			mem[i] = {i[1:0], i[7:0] ^ 8'h5a, i[7:0]};
		end
	end
	assign mem_rdata = mem[mem_rd_addr[3:0]];
	// Stalls hold the write head in the port's buffer
	assign mem_wr_ready = !stall;
	always @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			if (mem_wr_valid && mem_wr_ready && mem_wr_lanes[i]) begin
				mem[mem_wr_addr[3:0]][8*i +: 8] <= mem_wr_data[8*i +: 8];
				mem[mem_wr_addr[3:0]][16+i] <= mem_wr_data[16+i];
			end
		end
	end
endmodule // pbs_mem_model

// file: pbs_port_tb.sv
// Self-checking bench for the burst SRAM port.
// Assumes pbs_mem_model as the array; inputs change 1 ns after clk rises.
`timescale 1ns/100ps
module pbs_port_tb;
	logic clk = 1'b0, rst_b = 1'b0, stall = 1'b0;
	logic [19:0] addr_in = 20'h0;
	logic chip_sel_primary_n = 1'b1, chip_sel_second_high = 1'b0, chip_sel_third_n = 1'b1;
	logic cpu_addr_strobe_n = 1'b1, ctl_addr_strobe_n = 1'b1, burst_step_n = 1'b1;
	logic all_bytes_write_n = 1'b1, byte_write_gate_n = 1'b1, out_enable_n = 1'b0;
	logic sleep_req = 1'b0, burst_mode_sel = 1'b1, dq_oe, parity_oe, mem_wr_valid;
	logic mem_wr_ready, wbuf_ready, mem_sleep;
	logic [1:0] byte_lane_sel_n = 2'h3, parity_in = 2'h0, parity_out, mem_wr_lanes;
	logic [15:0] dq_in = 16'h0, dq_out;
	logic [19:0] mem_rd_addr, mem_wr_addr;
	logic [17:0] mem_rdata, mem_wr_data;
	logic [17:0] exp_mem [16];
	int num_errors = 0;
	int checked = 0;
	bit ok;
	always #25 clk = ~clk;
	pbs_port pbs_port_inst (.clk, .rst_b, .addr_in, .chip_sel_primary_n, .chip_sel_second_high,
		.chip_sel_third_n, .cpu_addr_strobe_n, .ctl_addr_strobe_n, .burst_step_n,
		.all_bytes_write_n, .byte_write_gate_n, .byte_lane_sel_n, .out_enable_n, .sleep_req,
		.burst_mode_sel, .dq_in, .dq_out, .dq_oe, .parity_in, .parity_out, .parity_oe,
		.mem_rd_addr, .mem_rdata, .mem_wr_valid, .mem_wr_ready, .mem_wr_addr, .mem_wr_data,
		.mem_wr_lanes, .wbuf_ready, .mem_sleep);
	pbs_mem_model pbs_mem_model_inst (.clk, .stall, .mem_rd_addr, .mem_rdata, .mem_wr_valid,
		.mem_wr_ready, .mem_wr_addr, .mem_wr_data, .mem_wr_lanes);
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [19:0] seen, input logic [19:0] want);
		checked++;
		if (seen !== want) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask
	task automatic results;
		if (num_errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic sel(input logic s2);
		chip_sel_primary_n = 1'b0;
		chip_sel_second_high = s2;
		chip_sel_third_n = 1'b0;
	endtask
	task automatic do_reset(input logic m);
		rst_b = 1'b0;
		burst_mode_sel = m;
		repeat (16) tick;
		rst_b = 1'b1;
		tick;
		tick;
	endtask
	task automatic burst(input logic [19:0] a, input logic ilv, input logic fresh);
		logic [1:0] lo;
		addr_in = a;
		sel(1'b1);
		cpu_addr_strobe_n = 1'b0;
		tick;
		cpu_addr_strobe_n = 1'b1;
		burst_step_n = 1'b0;
		if (fresh) chk(20'(dq_oe), 20'h1 - 20'h1);
		chk(mem_rd_addr, a);
		for (int b = 0; b < 4; b++) begin
			tick;
			lo = ilv ? a[1:0] ^ 2'(b) : a[1:0] + 2'(b);
			chk(20'({parity_out, dq_out}), 20'(exp_mem[{a[3:2], lo}]));
			chk(20'(dq_oe), 20'h1);
			lo = ilv ? a[1:0] ^ 2'(b + 1) : a[1:0] + 2'(b + 1);
			chk(mem_rd_addr, {a[19:2], lo});
		end
		burst_step_n = 1'b1;
		out_enable_n = 1'b1;
		#1 chk(20'({dq_oe, parity_oe}), 20'h0);
		out_enable_n = 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [17:0] d, input logic gw_n,
		input logic [1:0] ln_n);
		logic [1:0] m;
		m = !gw_n ? 2'h3 : ~ln_n;
		addr_in = {16'h0, a};
		sel(1'b1);
		ctl_addr_strobe_n = 1'b0;
		all_bytes_write_n = gw_n;
		byte_write_gate_n = 1'b0;
		byte_lane_sel_n = ln_n;
		{parity_in, dq_in} = d;
		tick;
		ctl_addr_strobe_n = 1'b1;
		all_bytes_write_n = 1'b1;
		byte_write_gate_n = 1'b1;
		byte_lane_sel_n = 2'h3;
		{parity_in, dq_in} = ~d;
		for (int i = 0; i < 2; i++) begin
			if (m[i]) begin
				exp_mem[a][8*i +: 8] = d[8*i +: 8];
				exp_mem[a][16+i] = d[16+i];
			end
		end
		// Keeps a following call from re-asserting the strobe in this step
		tick;
	endtask
	task automatic scn_wbuf(output bit done);
		stall = 1'b1;
		wr(4'h6, 18'h2a5c3, 1'b0, 2'h3);
		chk(20'(mem_wr_valid), 20'h1);
		chk(20'(mem_wr_lanes), 20'h3);
		chk(20'(mem_wr_data), 20'h2a5c3);
		chk(mem_wr_addr, 20'h6);
		wr(4'h6, 18'h15a3c, 1'b1, 2'h2);
		chk(20'(wbuf_ready), 20'h0);
		stall = 1'b0;
		tick;
		chk(20'(mem_wr_lanes), 20'h1);
		for (int i = 0; i < 8 && mem_wr_valid !== 1'b0; i++) tick;
		chk(20'(mem_wr_valid), 20'h0);
		done = (mem_wr_valid === 1'b0);
	endtask
	task automatic scn_desel;
		// Strobe with second select low deselects
		sel(1'b0);
		ctl_addr_strobe_n = 1'b0;
		tick;
		ctl_addr_strobe_n = 1'b1;
		tick;
		chk(20'(dq_oe), 20'h0);
	endtask
	task automatic scn_cpu_ignored;
		addr_in = 20'h3;
		sel(1'b1);
		chip_sel_primary_n = 1'b1;
		cpu_addr_strobe_n = 1'b0;
		tick;
		cpu_addr_strobe_n = 1'b1;
		tick;
		chk(20'(dq_oe), 20'h0);
		chk(mem_rd_addr, 20'h50006);
	endtask
	task automatic scn_sleep;
		sleep_req = 1'b1;
		repeat (6) tick;
		chk(20'(mem_sleep), 20'h1);
		sleep_req = 1'b0;
		repeat (6) tick;
		chk(20'(mem_sleep), 20'h0);
	endtask
	initial begin
		for (int i = 0; i < 16; i++) exp_mem[i] = {i[1:0], i[7:0] ^ 8'h5a, i[7:0]};
		do_reset(1'b1);
		burst(20'hab3c1, 1'b1, 1'b1);
		scn_wbuf(ok);
		if (ok) begin
			burst(20'h50006, 1'b1, 1'b0);
			scn_desel;
			scn_cpu_ignored;
			scn_sleep;
			do_reset(1'b0);
			burst(20'h00009, 1'b0, 1'b1);
		end
		results();
	end
endmodule // pbs_port_tb
